//--- vector_map_pkg.sv
package vector_map_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_IRQ = 25;
  localparam int unsigned NUM_VECTORS = 26;
  localparam int unsigned IDX_W = 5;

  localparam logic [ADDR_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [ADDR_W-1:0] FIRST_IRQ_VECTOR = 12'h001;
  localparam logic [ADDR_W-1:0] VECTOR_STEP = 12'h001;
  localparam logic [ADDR_W-1:0] BOOT_START_DEFAULT = 12'hc00;
  localparam logic BOOT_RESET_PROGRAMMED = 1'b0;

  // Request bit positions; vector address is FIRST_IRQ_VECTOR plus the position, plus BOOT_START when relocated.
  localparam int unsigned IRQ_EXT_ZERO = 0;
  localparam int unsigned IRQ_EXT_ONE = 1;
  localparam int unsigned IRQ_PIN_CHANGE0 = 2;
  localparam int unsigned IRQ_PIN_CHANGE2 = 4;
  localparam int unsigned IRQ_WATCHDOG = 5;
  localparam int unsigned IRQ_TIMER2_OVF = 8;
  localparam int unsigned IRQ_TIMER1_CAPT = 9;
  localparam int unsigned IRQ_TIMER1_OVF = 12;
  localparam int unsigned IRQ_TIMER0_OVF = 15;
  localparam int unsigned IRQ_SERIAL_PERIPH = 16;
  localparam int unsigned IRQ_USART_RX = 17;
  localparam int unsigned IRQ_USART_TX = 19;
  localparam int unsigned IRQ_ADC_DONE = 20;
  localparam int unsigned IRQ_EEPROM_READY = 21;
  localparam int unsigned IRQ_PROGRAM_STORE_READY = 24;

  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_IDLE = 3'h2,
    ST_VECTOR = 3'h4
  } mapper_state_t;

  typedef struct packed {
    logic valid;
    logic is_reset;
    logic [IDX_W-1:0] index;
    logic [ADDR_W-1:0] addr;
  } vector_out_t;

  typedef struct packed {
    mapper_state_t state;
    vector_out_t vec;
    logic vector_relocate_bit;
  } mapper_regs_t;

endpackage : vector_map_pkg

//--- irq_priority_pick.sv
`timescale 1ns/1ps
module irq_priority_pick #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned IDX_W = 5
) (
  input wire logic [WIDTH-1:0] req_i,
  output logic any_o,
  output logic [IDX_W-1:0] index_o
);

  // Scan from the top down so the lowest set position wins last.
  always_comb begin
    any_o = 1'b0;
    index_o = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        index_o = IDX_W'(i);
      end
    end
  end

endmodule : irq_priority_pick

//--- reset_irq_vector_mapper.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: After reset with boot-reset unprogrammed, fetch from 0x000.
// R2: External requests zero/one go to 0x001/0x002.
// R3: Pin-change groups 0..2 go to 0x003..0x005.
// R4: Watchdog 0x006; timer two at 0x007..0x009.
// R5: Timer one capture..overflow at 0x00A..0x00D.
// R6: Timer zero compares, overflow at 0x00E..0x010.
// R7: Serial peripheral transfer complete at 0x011.
// R8: USART receive, empty, transmit at 0x012..0x014.
// R9: Conversion complete vectors to 0x015.
// R10: EEPROM..program-store ready at 0x016..0x019; 26 vectors.
// R11: Programmed boot-reset starts at boot address.
// R12: Relocation adds boot start to every interrupt vector; the reset vector is unchanged.
// R13: One word per vector, step one.
// R14: Boot-reset stored zero means programmed.
// R15: Lowest pending vector address wins.
module reset_irq_vector_mapper #(
  parameter logic [vector_map_pkg::ADDR_W-1:0] BOOT_START = vector_map_pkg::BOOT_START_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic boot_reset_select_i,
  input wire logic vector_relocate_bit_i,
  input wire logic [vector_map_pkg::NUM_IRQ-1:0] irq_req_i,
  input wire logic global_irq_enable_i,
  input wire logic vector_taken_i,
  output logic vector_valid_o,
  output logic vector_is_reset_o,
  output logic [vector_map_pkg::IDX_W-1:0] vector_index_o,
  output logic [vector_map_pkg::ADDR_W-1:0] vector_addr_o,
  output logic vector_relocated_o
);
  import vector_map_pkg::*;

  mapper_regs_t regs_r;
  mapper_regs_t regs_nxt;
  logic pick_any;
  logic [IDX_W-1:0] pick_index;
  logic [NUM_IRQ-1:0] masked_req;
  logic [ADDR_W-1:0] table_base;
  logic [ADDR_W-1:0] reset_addr;

  // Only enabled requests take part in selection.
  assign masked_req = global_irq_enable_i ? irq_req_i : '0;

  irq_priority_pick #(
    .WIDTH(NUM_IRQ),
    .IDX_W(IDX_W)
  ) u_pick (
    .req_i(masked_req),
    .any_o(pick_any),
    .index_o(pick_index)
  ); // R15

  // The boot setting is a stored, static value; a change only acts at the next reset.
  assign reset_addr = (boot_reset_select_i == BOOT_RESET_PROGRAMMED) ? BOOT_START
                                                                     : RESET_VECTOR; // R1 R11 R14
  assign table_base = regs_r.vector_relocate_bit ? BOOT_START : '0; // R12

  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.vector_relocate_bit = vector_relocate_bit_i;
    case (regs_r.state)
      ST_RESET: begin
        // Present the reset target once after release, held until the core fetches it.
        regs_nxt.vec.valid = 1'b1;
        regs_nxt.vec.is_reset = 1'b1;
        regs_nxt.vec.index = '0;
        regs_nxt.vec.addr = reset_addr; // R1 R11
        regs_nxt.state = ST_VECTOR;
      end
      ST_IDLE: begin
        if (pick_any) begin
          regs_nxt.vec.valid = 1'b1;
          regs_nxt.vec.is_reset = 1'b0;
          regs_nxt.vec.index = pick_index;
          // Vectors are one word apart, starting right after reset.
          regs_nxt.vec.addr = table_base + FIRST_IRQ_VECTOR
                              + ADDR_W'(pick_index) * VECTOR_STEP; // R2 R3 R4 R5 R6 R7 R8 R9 R10 R12 R13
          regs_nxt.state = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        // The vector stays frozen while offered so the core never sees it change mid-fetch.
        if (vector_taken_i) begin
          regs_nxt.vec.valid = 1'b0;
          regs_nxt.vec.is_reset = 1'b0;
          regs_nxt.state = ST_IDLE;
        end
      end
      default: begin
        regs_nxt.state = ST_RESET;
        regs_nxt.vec = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_r.state <= ST_RESET;
      regs_r.vec.valid <= 1'b0;
      regs_r.vec.is_reset <= 1'b0;
      regs_r.vec.index <= '0;
      regs_r.vec.addr <= RESET_VECTOR; // R1
      regs_r.vector_relocate_bit <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign vector_valid_o = regs_r.vec.valid;
  assign vector_is_reset_o = regs_r.vec.is_reset;
  assign vector_index_o = regs_r.vec.index;
  assign vector_addr_o = regs_r.vec.addr;
  assign vector_relocated_o = regs_r.vector_relocate_bit;

endmodule : reset_irq_vector_mapper

//--- core_fetch_model.sv
`timescale 1ns/1ps
// The fetch side takes an offer at once unless stalled, so offers stand one or many cycles.
module core_fetch_model (
  input wire logic vector_valid_i,
  input wire logic stall_i,
  output logic vector_taken_o
);
  assign vector_taken_o = vector_valid_i & ~stall_i;
endmodule : core_fetch_model

//--- reset_irq_vector_mapper_checker.sv
`timescale 1ns/1ps
module vector_map_checker
  import vector_map_pkg::*;
#(parameter logic [ADDR_W-1:0] BOOT_START = BOOT_START_DEFAULT) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic boot_reset_select_i,
  input wire logic vector_relocate_bit_i,
  input wire logic [NUM_IRQ-1:0] irq_req_i,
  input wire logic global_irq_enable_i,
  input wire logic vector_taken_i,
  input wire logic vector_valid_o,
  input wire logic vector_is_reset_o,
  input wire logic [IDX_W-1:0] vector_index_o,
  input wire logic [ADDR_W-1:0] vector_addr_o,
  input wire logic vector_relocated_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  function automatic logic [IDX_W-1:0] low_idx(input logic [NUM_IRQ-1:0] r);
    low_idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) if (r[i]) low_idx = IDX_W'(i);
  endfunction : low_idx
  sequence s_pick;
    !vector_valid_o && $past(reset_n_i) && global_irq_enable_i && |irq_req_i;
  endsequence
  sequence s_offer;
    vector_valid_o && !vector_is_reset_o;
  endsequence
  AST_BOOT: assert property ($rose(reset_n_i) |=> vector_valid_o && vector_is_reset_o &&
    vector_addr_o == (boot_reset_select_i ? RESET_VECTOR : BOOT_START)) else $error("bad reset");
  AST_RST_IDX: assert property (vector_valid_o && vector_is_reset_o |-> vector_index_o == '0)
    else $error("bad reset index");
  AST_ADDR: assert property (s_offer |-> vector_addr_o == (vector_relocated_o ? BOOT_START :
    RESET_VECTOR) + FIRST_IRQ_VECTOR + ADDR_W'(vector_index_o)) else $error("bad address");
  AST_PICK: assert property (s_pick |=> s_offer ##0 vector_index_o == low_idx($past(irq_req_i)))
    else $error("bad pick");
  AST_HOLD: assert property (vector_valid_o && !vector_taken_i |=> vector_valid_o &&
    $stable(vector_addr_o) && $stable(vector_index_o)) else $error("offer moved");
  AST_DROP: assert property (vector_valid_o && vector_taken_i |=> !vector_valid_o)
    else $error("offer kept");
  AST_QUIET: assert property (!vector_valid_o && $past(reset_n_i) &&
    !(global_irq_enable_i && |irq_req_i) |=> !vector_valid_o) else $error("offer unasked");
  AST_REL: assert property ($past(reset_n_i) |-> vector_relocated_o == $past(vector_relocate_bit_i))
    else $error("bad relocate");
endmodule : vector_map_checker

//--- reset_irq_vector_mapper_bench.sv
`timescale 1ns/1ps
module reset_irq_vector_mapper_bench;
  import vector_map_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, boot_reset_select_i = 1, vector_relocate_bit_i = 0;
  logic global_irq_enable_i = 0, vector_taken_i, stall = 0, vector_valid_o, vector_is_reset_o;
  logic vector_relocated_o, ev, er, fresh, xr;
  logic [NUM_IRQ-1:0] irq_req_i = '0;
  logic [IDX_W-1:0] vector_index_o, ei;
  logic [ADDR_W-1:0] vector_addr_o, ea;
  int bad_count = 0, checks_done = 0, seed = 32'h4366e824;
  reset_irq_vector_mapper reset_irq_vector_mapper_i (.*);
  core_fetch_model core_fetch_model_i (.vector_valid_i(vector_valid_o), .stall_i(stall),
    .vector_taken_o(vector_taken_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [IDX_W-1:0] low_bit(input logic [NUM_IRQ-1:0] r);
    low_bit = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) if (r[i]) low_bit = IDX_W'(i);
  endfunction : low_bit
  // The relocation copy follows its control bit one cycle late and clears in reset.
  always @(posedge ref_clk_i or negedge reset_n_i) xr <= reset_n_i ? vector_relocate_bit_i : 1'b0;
  // Reference model of what the fetch side should be offered.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) {ev, fresh} = 2'h1;
    else if (fresh) begin
      {ev, er, ei, fresh} = {2'h3, 5'h00, 1'b0};
      ea = boot_reset_select_i ? RESET_VECTOR : BOOT_START_DEFAULT;
    end else if (ev) ev = !vector_taken_i;
    else if (global_irq_enable_i && |irq_req_i) begin
      {ev, er, ei} = {2'h2, low_bit(irq_req_i)};
      ea = (vector_relocate_bit_i ? BOOT_START_DEFAULT : RESET_VECTOR) + FIRST_IRQ_VECTOR +
        ADDR_W'(ei);
    end
  end
  always @(negedge ref_clk_i) if (reset_n_i) begin
    checks_done++;
    if (vector_valid_o !== ev || (ev && {vector_is_reset_o, vector_index_o, vector_addr_o} !==
      {er, ei, ea})) begin
      bad_count++;
      $display("Error %0t: vector mismatch", $time);
    end
    if (vector_relocated_o !== xr) begin
      bad_count++;
      $display("Error %0t: relocation copy mismatch", $time);
    end
  end
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Each pass after the first resets in mid-traffic; every pass gets a new boot and relocation setting.
  initial begin
    int r;
    for (int m = 0; m < 4; m++) begin
      reset_n_i <= 0;
      {boot_reset_select_i, vector_relocate_bit_i} <= m[1:0];
      repeat (16) @(posedge ref_clk_i);
      reset_n_i <= 1;
      for (int n = 0; n < 400; n++) begin
        @(posedge ref_clk_i);
        r = n < 100 ? 0 : $random(seed);
        stall <= r[0];
        global_irq_enable_i <= n < 100 || r[1] || r[2];
        irq_req_i <= n < 100 ? NUM_IRQ'(1) << (n / 4) : NUM_IRQ'(r) & NUM_IRQ'(r >> 7);
      end
    end
    wrap_up();
  end
endmodule : reset_irq_vector_mapper_bench
bind reset_irq_vector_mapper vector_map_checker #(.BOOT_START(BOOT_START)) vector_map_checker_i (.*);
